/* File: ccpc_core_model.sv */
/*
 * processor core model: issues one memory strobe at a time and measures
 * the cycles until the matching ready pulse.
 * assumes the design's outputs are registered on clock_i.
 */
`timescale 1ns/10ps
module ccpc_core_model (
    input  wire logic               clock_i,
    input  wire logic               cpu_clk_en_i,
    input  wire logic               prog_ready_i,
    input  wire logic               data_ready_i,
    output ccpc_pkg::ccpc_mem_req_t mem_o
);
    initial mem_o = '0;
    // kind 0 program read, 1 data read, 2 data write; strobe held until taken
    task automatic access(input int kind, output int lat);
        @(posedge clock_i);
        mem_o <= ccpc_pkg::ccpc_mem_req_t'(3'h4 >> kind);
        do @(posedge clock_i); while (cpu_clk_en_i !== 1'b1);
        mem_o <= '0;
        lat = 0;
        do begin
            @(posedge clock_i);
            lat++;
        end while ((kind == 0 ? prog_ready_i : data_ready_i) !== 1'b1 && lat < 64);
    endtask : access
endmodule : ccpc_core_model

/* File: ccpc_pkg.sv */
/*
 * package for the cpu clock and power control unit: register offsets, field
 * positions, reset values, key byte, wake-up warm-up counts and the carriers.
 * assumes nothing of its surroundings; every use is written ccpc_pkg::name.
 */
package ccpc_pkg;

    // register indices; the bus byte address is index times four
    localparam logic [7:0] REG_IDX_POWER   = 8'h87;
    localparam logic [7:0] REG_IDX_WAIT    = 8'h8e;
    localparam logic [7:0] REG_IDX_WAKE    = 8'h91;
    localparam logic [7:0] REG_IDX_DIV     = 8'he5;
    localparam logic [7:0] REG_IDX_CMD     = 8'he6;
    localparam logic [7:0] REG_IDX_STATUS  = 8'hf0;
    localparam int         ADDR_W          = 10;

    // memory_wait_config fields
    localparam int         PROG_WAIT_LSB   = 4;
    localparam int         WR_STRETCH_BIT  = 3;
    localparam int         DATA_WAIT_LSB   = 0;
    localparam logic [2:0] PROG_WAIT_RST   = 3'h7;
    localparam logic [2:0] DATA_WAIT_RST   = 3'h1;
    localparam logic [2:0] WR_STRETCH_CYC  = 3'h1;

    // cpu_clock_divider and commit key
    localparam logic [2:0] DIV_RST         = 3'h7;
    localparam logic [7:0] COMMIT_KEY      = 8'h69;

    // power_mode_control fields
    localparam int         IDLE_BIT        = 0;
    localparam int         STOP_BIT        = 1;
    localparam int         FLAG_BIT        = 2;
    localparam int         HSEL_BIT        = 3;
    localparam int         SERIAL_BIT      = 7;

    // wake-up warm-up figures, in oscillator and slow rc cycles
    localparam int         WARM_XTAL_FAST  = 2048;
    localparam int         WARM_RC_FAST    = 64;
    localparam int         WARM_SLOW       = 5;
    localparam int         WARM_W          = 12;

    typedef enum logic [1:0] {
        CCPC_RUN,
        CCPC_IDLE,
        CCPC_STOP,
        CCPC_WARM
    } ccpc_mode_t;

    // avalon request bundle
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } ccpc_bus_req_t;

    // memory access strobes from the core
    typedef struct packed {
        logic prog_read;
        logic data_read;
        logic data_write;
    } ccpc_mem_req_t;

endpackage : ccpc_pkg

/* File: ccpc_stretch.sv */
/*
 * memory access stretcher: holds a ready pulse back by a programmed number
 * of extra cycles after a start strobe.
 * assumes the start strobe comes from logic on the same clock.
 */
`timescale 1ns/10ps
module ccpc_stretch #(
    parameter int W = 3
) (
    input  wire logic         clock_i,
    input  wire logic         rst_n_i,
    input  wire logic         start_i,
    input  wire logic [W-1:0] extra_i,
    output logic              busy_o,
    output logic              done_o
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         busy;
        logic         done;
    } ccpc_st_t;

    ccpc_st_t s_q;
    ccpc_st_t s_d;

    // count down the extra cycles, then mark the access done
    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (s_q.busy) begin
            if (s_q.cnt == '0) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt - 1'b1;
            end
        end else if (start_i) begin
            s_d.busy = 1'b1;
            s_d.cnt  = extra_i;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy_o = s_q.busy;
    assign done_o = s_q.done;

endmodule : ccpc_stretch

/* File: ccpc_top.sv */
/*
 * cpu clock and power control: cpu clock enable divider with keyed commit,
 * program and data memory wait stretching, idle and stop modes with port
 * wake-up, and the high address byte for register-pointer data accesses.
 * assumes an avalon-mm master on clock_i, core strobes on clock_i, and
 * port pins from outside that are synchronised here.
 */
`timescale 1ns/10ps
// Functional notes
// - program reads stretched by program wait field
// - stretch bit adds cycles to data writes
// - data reads stretched by data wait field
// - divider code k divides by 2^(7-k)
// - new divider held pending until commit
// - key 0x69 in command commits divider
// - high byte select picks port2 or zero
// - stop bit enters stop mode
// - idle bit enters idle mode
// - port1 pin wakes only when masked in
// - idle gates cpu, wakes on pins/interrupts
// - stop halts all, wakes on pins only
// - warm-up delay before resuming after wake
module ccpc_top #(
    parameter int WARM_XTAL = ccpc_pkg::WARM_XTAL_FAST + ccpc_pkg::WARM_SLOW,
    parameter int WARM_RC   = ccpc_pkg::WARM_RC_FAST + ccpc_pkg::WARM_SLOW
) (
    input  wire logic                           clock_i,
    input  wire logic                           rst_n_i,
    input  wire ccpc_pkg::ccpc_bus_req_t        bus_i,
    output logic [31:0]                         readdata_o,
    output logic                                waitrequest_o,
    input  wire ccpc_pkg::ccpc_mem_req_t        mem_i,
    output logic                                prog_ready_o,
    output logic                                data_ready_o,
    input  wire logic [7:0]                     port2_output_register_i,
    output logic [7:0]                          xdata_high_o,
    input  wire logic [7:0]                     port0_pins_i,
    input  wire logic [7:0]                     port1_pins_i,
    input  wire logic                           irq_event_i,
    input  wire logic                           osc_is_rc_i,
    output logic                                cpu_clk_en_o,
    output logic                                periph_run_o,
    output logic                                osc_run_o,
    output logic [1:0]                          mode_o
);

    typedef struct packed {
        logic [7:0]           wait_cfg;
        logic [2:0]           div_pend;
        logic [2:0]           div_act;
        logic [7:0]           power;
        logic [7:0]           wake_mask;
        logic [6:0]           div_cnt;
        logic                 cpu_en;
        ccpc_pkg::ccpc_mode_t mode;
        logic [ccpc_pkg::WARM_W-1:0] warm;
        logic                 ack;
        logic [31:0]          rdata;
        logic [7:0]           p0_s1;
        logic [7:0]           p0_s2;
        logic [7:0]           p0_old;
        logic [7:0]           p1_s1;
        logic [7:0]           p1_s2;
        logic [7:0]           p1_old;
        logic [7:0]           xhigh;
        logic                 periph;
        logic                 osc;
    } ccpc_state_t;

    ccpc_state_t s_q;
    ccpc_state_t s_d;

    logic prog_busy;
    logic prog_done;
    logic data_busy;
    logic data_done;
    logic rd_done;
    logic wr_done;
    logic wr_busy;
    logic rd_busy;

    localparam int ADDRW = ccpc_pkg::ADDR_W;

    // division ratio as a mask of divider count bits
    function automatic logic [6:0] div_mask(input logic [2:0] code);
        return 7'(7'h7f >> code);
    endfunction : div_mask

    // read value of a register index, reserved bits as zero
    function automatic logic [7:0] reg_read(input logic [ADDRW-1:0] a,
                                           input ccpc_state_t s);
        logic [7:0] v;
        v = 8'h00;
        case (a[9:2])
            ccpc_pkg::REG_IDX_POWER:  v = s.power & 8'h8f;
            ccpc_pkg::REG_IDX_WAIT:   v = s.wait_cfg & 8'h7f;
            ccpc_pkg::REG_IDX_WAKE:   v = s.wake_mask;
            ccpc_pkg::REG_IDX_DIV:    v = {5'h00, s.div_pend};
            ccpc_pkg::REG_IDX_STATUS: v = {3'h0, s.div_act, 2'(s.mode)};
            default:                  v = 8'h00;   // command reg reads zero
        endcase
        return v;
    endfunction : reg_read

    // program memory stretch by field count
    ccpc_stretch #(.W(3)) u_prog (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .start_i (mem_i.prog_read & s_q.cpu_en & ~prog_busy),
        .extra_i (s_q.wait_cfg[ccpc_pkg::PROG_WAIT_LSB +: 3]),
        .busy_o  (prog_busy),
        .done_o  (prog_done)
    );

    // data memory stretch: reads by field writes by stretch bit
    ccpc_stretch #(.W(3)) u_data (
        .clock_i (clock_i),
        .rst_n_i (rst_n_i),
        .start_i ((mem_i.data_read | mem_i.data_write) & s_q.cpu_en & ~data_busy),
        .extra_i (mem_i.data_read ? s_q.wait_cfg[ccpc_pkg::DATA_WAIT_LSB +: 3]
                  : (s_q.wait_cfg[ccpc_pkg::WR_STRETCH_BIT] ? ccpc_pkg::WR_STRETCH_CYC
                                                           : 3'h0)),
        .busy_o  (data_busy),
        .done_o  (data_done)
    );

    assign rd_done = 1'b0;
    assign wr_done = 1'b0;
    assign wr_busy = 1'b0;
    assign rd_busy = 1'b0;

    // next-state logic for registers, divider, modes and bus answer
    always_comb begin
        logic       wr;
        logic       rd;
        logic [7:0] wb;
        logic       p0_chg;
        logic       p1_chg;
        logic       pw_wr;
        logic [ccpc_pkg::WARM_W-1:0] warm_len;
        s_d      = s_q;
        wr       = bus_i.write & s_q.ack;   // lands at the edge that completes the access
        rd       = bus_i.read & ~s_q.ack;
        wb       = bus_i.writedata[7:0];
        pw_wr    = wr & bus_i.byteenable[0] & (bus_i.address[9:2] == ccpc_pkg::REG_IDX_POWER);
        p0_chg   = |(s_q.p0_s2 ^ s_q.p0_old);
        p1_chg   = |((s_q.p1_s2 ^ s_q.p1_old) & s_q.wake_mask);
        warm_len = osc_is_rc_i ? ccpc_pkg::WARM_W'(WARM_RC)
                               : ccpc_pkg::WARM_W'(WARM_XTAL);

        // pin synchronisers and change history
        s_d.p0_s1  = port0_pins_i;
        s_d.p0_s2  = s_q.p0_s1;
        s_d.p0_old = s_q.p0_s2;
        s_d.p1_s1  = port1_pins_i;
        s_d.p1_s2  = s_q.p1_s1;
        s_d.p1_old = s_q.p1_s2;

        // bus slave: one wait cycle, then ack
        s_d.ack = (bus_i.read | bus_i.write) & ~s_q.ack;
        if (rd) begin
            s_d.rdata = {24'h000000, reg_read(bus_i.address, s_q)};
        end
        if (wr && bus_i.byteenable[0]) begin
            case (bus_i.address[9:2])
                ccpc_pkg::REG_IDX_POWER: s_d.power = wb & 8'h8f;
                ccpc_pkg::REG_IDX_WAIT:  s_d.wait_cfg = wb & 8'h7f;
                ccpc_pkg::REG_IDX_WAKE:  s_d.wake_mask = wb;
                ccpc_pkg::REG_IDX_DIV:   s_d.div_pend = wb[2:0];   // held pending
                ccpc_pkg::REG_IDX_CMD: begin
                    if (wb == ccpc_pkg::COMMIT_KEY) begin
                        s_d.div_act = s_q.div_pend;
                    end   // other values ignored
                end
                default: ;
            endcase
        end

        // power mode sequencing
        case (s_q.mode)
            ccpc_pkg::CCPC_RUN: begin
                if (s_q.power[ccpc_pkg::STOP_BIT]) begin
                    s_d.mode = ccpc_pkg::CCPC_STOP;
                end else if (s_q.power[ccpc_pkg::IDLE_BIT]) begin
                    s_d.mode = ccpc_pkg::CCPC_IDLE;
                end
            end
            ccpc_pkg::CCPC_IDLE: begin
                if (p0_chg || p1_chg || irq_event_i) begin
                    s_d.mode = ccpc_pkg::CCPC_WARM;
                    s_d.warm = warm_len;
                    if (!pw_wr) begin   // a software write in the same cycle wins
                        s_d.power[ccpc_pkg::IDLE_BIT] = 1'b0;
                    end
                end
            end
            ccpc_pkg::CCPC_STOP: begin
                if (p0_chg || p1_chg) begin
                    s_d.mode = ccpc_pkg::CCPC_WARM;
                    s_d.warm = warm_len;
                    if (!pw_wr) begin   // a software write in the same cycle wins
                        s_d.power[ccpc_pkg::STOP_BIT] = 1'b0;
                    end
                end
            end
            ccpc_pkg::CCPC_WARM: begin
                if (s_q.warm == '0) begin
                    s_d.mode = ccpc_pkg::CCPC_RUN;
                end else begin
                    s_d.warm = s_q.warm - 1'b1;
                end
            end
            default: s_d.mode = ccpc_pkg::CCPC_RUN;
        endcase

        // cpu clock enable divider, dropped in the cycle the mode leaves run
        s_d.div_cnt = s_q.div_cnt + 7'h01;
        s_d.cpu_en  = 1'b0;
        if ((s_q.div_cnt & div_mask(s_q.div_act)) == 7'h00 && s_d.mode == ccpc_pkg::CCPC_RUN) begin
            s_d.cpu_en = 1'b1;
        end

        // idle keeps peripherals and oscillator, stop halts both
        s_d.periph = (s_d.mode != ccpc_pkg::CCPC_STOP);
        s_d.osc    = (s_d.mode != ccpc_pkg::CCPC_STOP);

        // high address byte for register-pointer data accesses
        s_d.xhigh = s_q.power[ccpc_pkg::HSEL_BIT] ? 8'h00 : port2_output_register_i;
    end

    // state register with documented reset values
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            s_q          <= '0;
            s_q.wait_cfg <= {1'b0, ccpc_pkg::PROG_WAIT_RST, 1'b0, ccpc_pkg::DATA_WAIT_RST};
            s_q.div_pend <= ccpc_pkg::DIV_RST;
            s_q.div_act  <= ccpc_pkg::DIV_RST;
            s_q.power    <= 8'h08;   // high byte select resets to one
            s_q.mode     <= ccpc_pkg::CCPC_RUN;
            s_q.periph   <= 1'b1;
            s_q.osc      <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ready pulses registered once more so outputs come from flops
    logic prog_rdy_q;
    logic data_rdy_q;
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            prog_rdy_q <= 1'b0;
            data_rdy_q <= 1'b0;
        end else begin
            prog_rdy_q <= prog_done;
            data_rdy_q <= data_done;
        end
    end

    assign readdata_o    = s_q.rdata;
    assign waitrequest_o = ~s_q.ack;
    assign prog_ready_o  = prog_rdy_q;
    assign data_ready_o  = data_rdy_q;
    assign xdata_high_o  = s_q.xhigh;
    assign cpu_clk_en_o  = s_q.cpu_en;
    assign periph_run_o  = s_q.periph;
    assign osc_run_o     = s_q.osc;
    assign mode_o        = 2'(s_q.mode);

endmodule : ccpc_top

/* File: ccpc_top_asserts.sv */
/*
 * checker for ccpc_top: register reads, memory stretch bounds, high byte,
 * idle and stop behaviour and warm-up length. assumes ccpc_pkg is compiled
 * first; it is bound to the design at the foot of this file.
 */
`timescale 1ns/10ps
module ccpc_top_asserts #(
    parameter int WARM_XTAL = 2053,
    parameter int WARM_RC   = 69
) (
    input wire logic                    clock_i,
    input wire logic                    rst_n_i,
    input wire ccpc_pkg::ccpc_bus_req_t bus_i,
    input wire logic [31:0]             readdata_o,
    input wire logic                    waitrequest_o,
    input wire ccpc_pkg::ccpc_mem_req_t mem_i,
    input wire logic                    prog_ready_o,
    input wire logic                    data_ready_o,
    input wire logic [7:0]              port2_output_register_i,
    input wire logic [7:0]              xdata_high_o,
    input wire logic [7:0]              port0_pins_i,
    input wire logic [7:0]              port1_pins_i,
    input wire logic                    irq_event_i,
    input wire logic                    osc_is_rc_i,
    input wire logic                    cpu_clk_en_o,
    input wire logic                    periph_run_o,
    input wire logic                    osc_run_o,
    input wire logic [1:0]              mode_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    logic [11:0] warm_q;
    logic        pw_w;
    int          lim;
    // a completed write to the power register, and the warm-up target
    assign pw_w = !waitrequest_o && bus_i.write && bus_i.byteenable[0]
                  && bus_i.address == {ccpc_pkg::REG_IDX_POWER, 2'h0};
    assign lim  = osc_is_rc_i ? WARM_RC : WARM_XTAL;
    // counts consecutive warm-up cycles
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            warm_q <= 12'h0;
        end else begin
            warm_q <= (mode_o == 2'h3) ? warm_q + 12'h1 : 12'h0;
        end
    end
    sequence s_pins_quiet;
        ($stable(port0_pins_i) && $stable(port1_pins_i)) [*6];
    endsequence
    sequence s_warm_exit;
        mode_o == 2'h3 ##1 mode_o == 2'h0;
    endsequence
    property p_cmd_zero;
        !waitrequest_o && bus_i.read && bus_i.address == {ccpc_pkg::REG_IDX_CMD, 2'h0}
            |-> readdata_o == 32'h0;
    endproperty
    property p_xdata;
        xdata_high_o != 8'h0 |-> xdata_high_o == $past(port2_output_register_i);
    endproperty
    property p_idle_out;
        mode_o == 2'h1 |-> !cpu_clk_en_o && periph_run_o && osc_run_o;
    endproperty
    property p_stop_out;
        mode_o == 2'h2 |-> !cpu_clk_en_o && !periph_run_o && !osc_run_o;
    endproperty
    property p_idle_wake;
        mode_o == 2'h1 && irq_event_i |-> ##[1:3] mode_o != 2'h1;
    endproperty
    property p_stop_hold;
        s_pins_quiet ##0 (mode_o == 2'h2 && irq_event_i) |=> mode_o == 2'h2;
    endproperty
    property p_prog_bound;
        mem_i.prog_read && cpu_clk_en_o |-> ##[1:10] prog_ready_o;
    endproperty
    property p_data_bound;
        (mem_i.data_read || mem_i.data_write) && cpu_clk_en_o |-> ##[1:10] data_ready_o;
    endproperty
    property p_stop_enter;
        pw_w && bus_i.writedata[1:0] == 2'h2 |-> ##[1:3] mode_o == 2'h2;
    endproperty
    property p_warm_len;
        s_warm_exit |-> warm_q >= lim && warm_q <= lim + 2;
    endproperty
    a_cmd_zero: assert property (p_cmd_zero)
        else $error("command read not zero");
    a_xdata: assert property (p_xdata)
        else $error("high byte not port2 value");
    a_idle_out: assert property (p_idle_out)
        else $error("idle run outputs wrong");
    a_stop_out: assert property (p_stop_out)
        else $error("stop run outputs wrong");
    a_idle_wake: assert property (p_idle_wake)
        else $error("interrupt did not end idle");
    a_stop_hold: assert property (p_stop_hold)
        else $error("interrupt ended stop");
    a_prog_bound: assert property (p_prog_bound)
        else $error("program read ready late");
    a_data_bound: assert property (p_data_bound)
        else $error("data access ready late");
    a_stop_enter: assert property (p_stop_enter)
        else $error("stop not entered");
    a_warm_len: assert property (p_warm_len)
        else $error("warm-up length wrong");
endmodule : ccpc_top_asserts

bind ccpc_top ccpc_top_asserts #(.WARM_XTAL(WARM_XTAL), .WARM_RC(WARM_RC)) ccpc_top_asserts_i (
    .clock_i, .rst_n_i, .bus_i, .readdata_o, .waitrequest_o, .mem_i, .prog_ready_o,
    .data_ready_o, .port2_output_register_i, .xdata_high_o, .port0_pins_i,
    .port1_pins_i, .irq_event_i, .osc_is_rc_i, .cpu_clk_en_o, .periph_run_o,
    .osc_run_o, .mode_o
);

/* File: tb.sv */
/*
 * bench for ccpc_top: reset values, keyed divider commit, memory stretch,
 * high byte select, idle and stop with wake-up and warm-up.
 * assumes ccpc_pkg, the design, its checker and the core model compiled.
 */
`timescale 1ns/10ps
`define CHK(n, e, g) check(n, 32'(e), 32'(g));
module tb;
    localparam int WR = 8; // short rc warm-up for simulation
    localparam int LAT0 = 3; // model cycles from taken strobe to ready, no extra cycles
    logic                    clock_i = 1'b0;
    logic                    rst_n_i = 1'b0;
    ccpc_pkg::ccpc_bus_req_t bus_q   = '0;
    ccpc_pkg::ccpc_mem_req_t mem_w;
    logic [31:0]             readdata_o, rd_v;
    logic                    waitrequest_o, prog_ready_o, data_ready_o;
    logic [7:0]              xdata_high_o;
    logic [7:0]              p1_q    = 8'h0;
    logic                    irq_q   = 1'b0;
    logic                    cpu_clk_en_o, periph_run_o, osc_run_o;
    logic [1:0]              mode_o;
    int                      n_mismatch = 0;
    int                      n_checks   = 0;
    int                      cyc        = 0;
    int                      v;
    logic [7:0]              cfg [3]    = '{8'h71, 8'h38, 8'h07};

    always #5 clock_i = ~clock_i;

    ccpc_top #(.WARM_XTAL(20), .WARM_RC(WR)) ccpc_top_i (
        .clock_i                 (clock_i),
        .rst_n_i                 (rst_n_i),
        .bus_i                   (bus_q),
        .readdata_o              (readdata_o),
        .waitrequest_o           (waitrequest_o),
        .mem_i                   (mem_w),
        .prog_ready_o            (prog_ready_o),
        .data_ready_o            (data_ready_o),
        .port2_output_register_i (8'ha5),
        .xdata_high_o            (xdata_high_o),
        .port0_pins_i            (8'h00),
        .port1_pins_i            (p1_q),
        .irq_event_i             (irq_q),
        .osc_is_rc_i             (1'b1),
        .cpu_clk_en_o            (cpu_clk_en_o),
        .periph_run_o            (periph_run_o),
        .osc_run_o               (osc_run_o),
        .mode_o                  (mode_o)
    );
    ccpc_core_model core_i (
        .clock_i      (clock_i),
        .cpu_clk_en_i (cpu_clk_en_o),
        .prog_ready_i (prog_ready_o),
        .data_ready_i (data_ready_o),
        .mem_o        (mem_w)
    );

    task automatic summarize();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : summarize
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : check
    // one avalon access, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        bus_q.address    <= {a, 2'h0};
        bus_q.read       <= !w;
        bus_q.write      <= w;
        bus_q.writedata  <= {24'h0, d};
        bus_q.byteenable <= 4'hf;
        do @(posedge clock_i); while (waitrequest_o !== 1'b0);
        rd_v = readdata_o;
        bus_q.read  <= 1'b0;
        bus_q.write <= 1'b0;
        @(posedge clock_i);
    endtask : bus
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h0);
        check($sformatf("register %h", a), {24'h0, e}, rd_v);
    endtask : rd
    task automatic wait_mode(input logic [1:0] m);
        v = 0;
        while (mode_o !== m && v < 200) begin
            @(posedge clock_i);
            v++;
        end
    endtask : wait_mode
    // cycles between two cpu clock enables
    task automatic period();
        v = 0;
        do @(posedge clock_i); while (cpu_clk_en_o !== 1'b1);
        do begin
            @(posedge clock_i);
            v++;
        end while (cpu_clk_en_o !== 1'b1 && v < 300);
    endtask : period

    // hang guard
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end

    // main sequence
    initial begin
        repeat (6) @(posedge clock_i);
        rst_n_i <= 1'b1;
        @(posedge clock_i);
        `CHK("xdata_high_o", 8'h00, xdata_high_o)
        rd(ccpc_pkg::REG_IDX_WAIT, 8'h71);
        rd(ccpc_pkg::REG_IDX_POWER, 8'h08);
        rd(ccpc_pkg::REG_IDX_WAKE, 8'h00);
        rd(ccpc_pkg::REG_IDX_DIV, 8'h07);
        rd(ccpc_pkg::REG_IDX_CMD, 8'h00);
        rd(8'h10, 8'h00);
        bus(1'b1, ccpc_pkg::REG_IDX_DIV, 8'h03);
        rd(ccpc_pkg::REG_IDX_STATUS, 8'h1c);
        bus(1'b1, ccpc_pkg::REG_IDX_CMD, 8'h12);
        rd(ccpc_pkg::REG_IDX_STATUS, 8'h1c);
        rd(ccpc_pkg::REG_IDX_DIV, 8'h03);
        for (int k = 0; k < 8; k++) begin
            bus(1'b1, ccpc_pkg::REG_IDX_DIV, 8'(k));
            bus(1'b1, ccpc_pkg::REG_IDX_CMD, ccpc_pkg::COMMIT_KEY);
            rd(ccpc_pkg::REG_IDX_STATUS, 8'(k << 2));
            period();
            `CHK("cpu_clk_en period", 1 << (7 - k), v)
        end
        foreach (cfg[i]) begin
            bus(1'b1, ccpc_pkg::REG_IDX_WAIT, cfg[i]);
            core_i.access(0, v);
            `CHK("program latency", cfg[i][6:4] + LAT0, v)
            core_i.access(1, v);
            `CHK("read latency", cfg[i][2:0] + LAT0, v)
            core_i.access(2, v);
            `CHK("write latency", cfg[i][3] + LAT0, v)
        end
        bus(1'b1, ccpc_pkg::REG_IDX_POWER, 8'h00);
        repeat (2) @(posedge clock_i);
        `CHK("xdata_high_o", 8'ha5, xdata_high_o)
        bus(1'b1, ccpc_pkg::REG_IDX_POWER, 8'h08);
        repeat (2) @(posedge clock_i);
        `CHK("xdata_high_o", 8'h00, xdata_high_o)
        bus(1'b1, ccpc_pkg::REG_IDX_POWER, 8'h09);
        repeat (3) @(posedge clock_i);
        `CHK("mode_o", 2'h1, mode_o)
        `CHK("run outputs", 3'h3, {cpu_clk_en_o, periph_run_o, osc_run_o})
        irq_q <= 1'b1;
        @(posedge clock_i);
        irq_q <= 1'b0;
        wait_mode(2'h0);
        rd(ccpc_pkg::REG_IDX_POWER, 8'h08);
        bus(1'b1, ccpc_pkg::REG_IDX_WAKE, 8'h01);
        bus(1'b1, ccpc_pkg::REG_IDX_POWER, 8'h0a);
        repeat (8) @(posedge clock_i);
        `CHK("mode_o", 2'h2, mode_o)
        `CHK("run outputs", 3'h0, {cpu_clk_en_o, periph_run_o, osc_run_o})
        irq_q <= 1'b1;
        @(posedge clock_i);
        irq_q <= 1'b0;
        p1_q  <= 8'h02;
        repeat (8) @(posedge clock_i);
        `CHK("mode_o", 2'h2, mode_o)
        p1_q <= 8'h03;
        wait_mode(2'h3);
        wait_mode(2'h0);
        `CHK("warm-up in range", 1'b1, v >= WR && v <= WR + 2)
        rd(ccpc_pkg::REG_IDX_POWER, 8'h08);
        summarize();
    end
endmodule : tb
